// file: hdl/etc_totalizer.sv
// Edge totalizer control for one module slot: command decode, settings, query responder
// Overview of operation
// - Each channel counts on its own selected edge, rising or falling across the threshold.
// - The configure operation sets the listed channels to rising edge.
// - A factory reset sets every channel back to rising edge.
// - A preset or a card reset leaves the edge selections as they are.
// - An edge query answers the falling or rising name for each listed channel in order, comma separated.
// - A start request enables counting at once on every listed channel.
// - A stop request disables counting at once on every listed channel.
// - Each channel has a power-on start flag that makes it count right after power-up.
// - A power-on start query answers 1 or 0 per listed channel, comma separated.
// - Channels are local numbers five to eight, addressed behind the slot number.
// - A request with no channels listed applies to every channel of the scan list.
// - Each count is an unsigned 32-bit value that wraps to zero past its maximum.
// - A factory reset clears every count; a preset or a card reset keeps it.
// - In read-and-clear mode a read returns the count and then zeroes it; plain read keeps it.
`timescale 1ns/100ps
module etc_totalizer
  import etc_pkg::*;
#(
  parameter int N = CHAN_COUNT,
  parameter int W = COUNT_WIDTH,
  parameter logic [SLOT_WIDTH-1:0] SLOT_ID = 4'h1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Counting inputs
  input wire logic [N-1:0] pulse_in,
  // Command port
  input wire logic cmd_valid,
  input wire etc_op_type cmd_op,
  input wire logic [SLOT_WIDTH-1:0] cmd_slot,
  input wire logic [N-1:0] cmd_chans,
  input wire logic cmd_falling_edge_select,
  input wire logic cmd_read_and_clear_mode,
  output logic cmd_ready,
  // Scan list and stored power-on flags
  input wire logic [N-1:0] scan_list,
  input wire logic [N-1:0] pon_start_stored,
  // Response stream
  output logic resp_valid,
  output etc_resp_type resp_kind,
  output logic [7:0] resp_char,
  output logic [W-1:0] resp_count,
  output logic [SLOT_WIDTH-1:0] resp_slot,
  output logic [LOCAL_WIDTH-1:0] resp_local,
  output logic resp_last,
  // Status
  output logic [N-1:0] falling_edge_select,
  output logic [N-1:0] read_and_clear_mode,
  output logic [N-1:0] count_enabled,
  output logic [N-1:0] pon_start_flag
);

  typedef enum logic [1:0] {ST_IDLE, ST_ITEM, ST_SEP} etc_state_type;

  localparam int IDX_W = $clog2(N);

  etc_chan_if #(.N(N), .W(W)) chan ();

  etc_state_type state_reg;
  etc_op_type q_op_reg;
  logic [N-1:0] q_mask_reg;
  logic [IDX_W-1:0] ch_idx_reg;
  logic [CHAR_IDX_WIDTH-1:0] char_idx_reg;
  logic init_reg;
  logic [N-1:0] slope_reg;
  logic [N-1:0] mode_reg;
  logic [N-1:0] enable_reg;
  logic [N-1:0] pon_reg;
  logic [N-1:0] sel;
  logic [N-1:0] rest_mask;
  logic take;
  logic here;
  logic is_text;
  logic item_done;
  logic [CHAR_IDX_WIDTH-1:0] text_last;
  logic [7:0] item_char;
  logic [23:0] edge_text;

  // Global operations act on the whole slot, the rest only on its own address
  assign here = (cmd_slot == SLOT_ID) || (cmd_op == OP_FACTORY_RESET) || (cmd_op == OP_PRESET)
    || (cmd_op == OP_CARD_RESET);
  assign take = clk_en && cmd_valid && cmd_ready && here;
  assign sel = (cmd_chans == '0) ? scan_list : cmd_chans;

  assign is_text = (q_op_reg == OP_QUERY_SLOPE) || (q_op_reg == OP_QUERY_START_DEFAULT);
  assign text_last = (q_op_reg == OP_QUERY_SLOPE) ? TEXT_EDGE_LAST : '0;
  assign item_done = !is_text || (char_idx_reg == text_last);
  assign rest_mask = q_mask_reg & ~((N'(2) << ch_idx_reg) - N'(1));
  assign edge_text = slope_reg[ch_idx_reg] ? TEXT_FALLING : TEXT_RISING;

  // Text of one item: edge name or power-on flag digit
  always_comb begin
    item_char = CHAR_ZERO;
    if (q_op_reg == OP_QUERY_SLOPE) begin
      item_char = edge_text[8 * (2 - int'(char_idx_reg)) +: 8];
    end else if (pon_reg[ch_idx_reg]) begin
      item_char = CHAR_ONE;
    end
  end

  // Counter bank controls
  always_comb begin
    chan.clear = '0;
    if (take && (cmd_op == OP_FACTORY_RESET)) begin
      chan.clear = '1;
    end else if (take && (cmd_op == OP_CLEAR)) begin
      chan.clear = sel;
    end
    if (clk_en && (state_reg == ST_ITEM) && (q_op_reg == OP_READ) && q_mask_reg[ch_idx_reg]
        && mode_reg[ch_idx_reg]) begin
      chan.clear[ch_idx_reg] = 1'h1;
    end
  end
  assign chan.slope_falling = slope_reg;
  assign chan.count_en = enable_reg;

  etc_counter_bank #(.N(N), .W(W)) u_bank (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pulse_in(pulse_in),
    .chan(chan)
  );

  // Edge selection
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slope_reg <= {N{SLOPE_RESET}};
    end else if (clk_en && take) begin
      if (cmd_op == OP_FACTORY_RESET) begin
        slope_reg <= {N{SLOPE_RESET}};
      end else if (cmd_op == OP_CONFIGURE) begin
        slope_reg <= slope_reg & ~sel;
      end else if (cmd_op == OP_SET_SLOPE) begin
        slope_reg <= cmd_falling_edge_select ? (slope_reg | sel) : (slope_reg & ~sel);
      end
    end // Preset and card reset fall through untouched
  end

  // Read mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= {N{MODE_RESET}};
    end else if (clk_en && take) begin
      if (cmd_op == OP_FACTORY_RESET) begin
        mode_reg <= {N{MODE_RESET}};
      end else if (cmd_op == OP_CONFIGURE) begin
        mode_reg <= mode_reg & ~sel;
      end else if (cmd_op == OP_SET_MODE) begin
        mode_reg <= cmd_read_and_clear_mode ? (mode_reg | sel) : (mode_reg & ~sel);
      end
    end
  end

  // Power-on flags: stored copy loaded after reset release, then set by command
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pon_reg <= {N{PON_RESET}};
      init_reg <= 1'h0;
    end else if (clk_en) begin
      init_reg <= 1'h1;
      if (!init_reg) begin
        pon_reg <= pon_start_stored;
      end else if (take && (cmd_op == OP_START_DEFAULT)) begin
        pon_reg <= pon_reg | sel;
      end
    end
  end

  // Counting enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enable_reg <= {N{ENABLE_RESET}};
    end else if (clk_en) begin
      if (!init_reg) begin
        enable_reg <= pon_start_stored;
      end else if (take && (cmd_op == OP_START)) begin
        enable_reg <= enable_reg | sel;
      end else if (take && (cmd_op == OP_STOP)) begin
        enable_reg <= enable_reg & ~sel;
      end
    end
  end

  // Query responder
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      q_op_reg <= OP_NONE;
      q_mask_reg <= '0;
      ch_idx_reg <= '0;
      char_idx_reg <= '0;
      cmd_ready <= 1'h0;
      resp_valid <= 1'h0;
      resp_kind <= RESP_NONE;
      resp_char <= 8'h00;
      resp_count <= '0;
      resp_slot <= SLOT_ID;
      resp_local <= 4'h0;
      resp_last <= 1'h0;
    end else if (clk_en) begin
      resp_valid <= 1'h0;
      resp_last <= 1'h0;
      case (state_reg)
        ST_IDLE: begin
          cmd_ready <= init_reg;
          if (take && (sel != '0) && ((cmd_op == OP_QUERY_SLOPE) || (cmd_op == OP_QUERY_START_DEFAULT)
              || (cmd_op == OP_READ))) begin
            state_reg <= ST_ITEM;
            q_op_reg <= cmd_op;
            q_mask_reg <= sel;
            ch_idx_reg <= '0;
            char_idx_reg <= '0;
            cmd_ready <= 1'h0;
          end
        end
        ST_ITEM: begin
          if (!q_mask_reg[ch_idx_reg]) begin
            ch_idx_reg <= ch_idx_reg + IDX_W'(1);
          end else begin
            resp_valid <= 1'h1;
            resp_kind <= is_text ? RESP_TEXT : RESP_COUNT;
            resp_char <= is_text ? item_char : 8'h00;
            resp_count <= is_text ? '0 : chan.count[ch_idx_reg];
            resp_local <= LOCAL_WIDTH'(CHAN_FIRST_LOCAL + int'(ch_idx_reg));
            char_idx_reg <= char_idx_reg + CHAR_IDX_WIDTH'(1);
            if (item_done) begin
              char_idx_reg <= '0;
              if (rest_mask == '0) begin
                resp_last <= 1'h1;
                state_reg <= ST_IDLE;
              end else begin
                state_reg <= is_text ? ST_SEP : ST_ITEM;
                ch_idx_reg <= ch_idx_reg + IDX_W'(1);
              end
            end
          end
        end
        ST_SEP: begin
          resp_valid <= 1'h1;
          resp_kind <= RESP_TEXT;
          resp_char <= CHAR_COMMA;
          state_reg <= ST_ITEM;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Status copies
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      falling_edge_select <= {N{SLOPE_RESET}};
      read_and_clear_mode <= {N{MODE_RESET}};
      count_enabled <= {N{ENABLE_RESET}};
      pon_start_flag <= {N{PON_RESET}};
    end else if (clk_en) begin
      falling_edge_select <= slope_reg;
      read_and_clear_mode <= mode_reg;
      count_enabled <= enable_reg;
      pon_start_flag <= pon_reg;
    end
  end

endmodule

// file: hdl/etc_pkg.sv
// Shared constants and types for the edge totalizer control block
package etc_pkg;

  localparam int CHAN_COUNT = 4;
  localparam int CHAN_FIRST_LOCAL = 5;
  localparam int COUNT_WIDTH = 32;
  localparam int SLOT_WIDTH = 4;
  localparam int LOCAL_WIDTH = 4;
  localparam int CHAR_IDX_WIDTH = 2;

  // Reset values: rising edge, plain read, stopped, no power-on start
  localparam logic SLOPE_RESET = 1'h0;
  localparam logic MODE_RESET = 1'h0;
  localparam logic ENABLE_RESET = 1'h0;
  localparam logic PON_RESET = 1'h0;

  // Response text
  localparam logic [7:0] CHAR_COMMA = 8'h2C;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_ONE = 8'h31;
  localparam logic [23:0] TEXT_FALLING = 24'h4E4547;
  localparam logic [23:0] TEXT_RISING = 24'h504F53;
  localparam logic [CHAR_IDX_WIDTH-1:0] TEXT_EDGE_LAST = 2'h2;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_CONFIGURE,
    OP_SET_SLOPE,
    OP_QUERY_SLOPE,
    OP_START,
    OP_STOP,
    OP_START_DEFAULT,
    OP_QUERY_START_DEFAULT,
    OP_CLEAR,
    OP_READ,
    OP_SET_MODE,
    OP_FACTORY_RESET,
    OP_PRESET,
    OP_CARD_RESET
  } etc_op_type;

  typedef enum logic [1:0] {
    RESP_NONE,
    RESP_TEXT,
    RESP_COUNT
  } etc_resp_type;

endpackage

// file: hdl/etc_chan_if.sv
// Control and count bundle between the totalizer control and its counter bank
`timescale 1ns/100ps
interface etc_chan_if #(
  parameter int N = 4,
  parameter int W = 32
);
  logic [N-1:0] slope_falling;
  logic [N-1:0] count_en;
  logic [N-1:0] clear;
  logic [N-1:0][W-1:0] count;

  modport ctrl (
    output slope_falling,
    output count_en,
    output clear,
    input count
  );

  modport bank (
    input slope_falling,
    input count_en,
    input clear,
    output count
  );
endinterface

// file: hdl/etc_counter_bank.sv
// Per-channel edge detectors and wrapping event counters
`timescale 1ns/100ps
module etc_counter_bank
  import etc_pkg::*;
#(
  parameter int N = CHAN_COUNT,
  parameter int W = COUNT_WIDTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Pulse inputs, after the threshold comparators
  input wire logic [N-1:0] pulse_in,
  // Control and counts
  etc_chan_if.bank chan
);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_chan
      logic prev_reg;
      logic edge_hit;
      logic [W-1:0] count_reg;

      // Selected crossing, per channel
      assign edge_hit = chan.slope_falling[g] ? (prev_reg & ~pulse_in[g]) : (~prev_reg & pulse_in[g]);

      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          prev_reg <= 1'h0;
        end else if (clk_en) begin
          prev_reg <= pulse_in[g];
        end
      end

      // Clear restarts from zero but keeps an edge of the same cycle
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          count_reg <= '0;
        end else if (clk_en) begin
          if (chan.clear[g]) begin
            count_reg <= W'(chan.count_en[g] & edge_hit);
          end else if (chan.count_en[g] && edge_hit) begin
            count_reg <= count_reg + W'(1);
          end
        end
      end // Disabled channel holds its count

      assign chan.count[g] = count_reg;
    end
  endgenerate

endmodule

// file: tb/etc_pulse_src.sv
// Pulse source model driving the totalizer counting inputs
`timescale 1ns/100ps
module etc_pulse_src (
  // Clock
  input wire logic core_clk,
  // Counting levels, bit i feeds local channel 5+i
  output logic [3:0] pulse_in
);
  initial pulse_in = 4'h0;
  // Toggle every line n times, two cycles apart, so both edge kinds occur
  task automatic burst(input int n);
    repeat (n) begin
      repeat (2) @(negedge core_clk);
      pulse_in = ~pulse_in;
    end
  endtask
endmodule

// file: tb/etc_totalizer_chk.sv
// Port checker for the edge totalizer control
`timescale 1ns/100ps
module etc_totalizer_chk
  import etc_pkg::*;
#(
  parameter int N = CHAN_COUNT,
  parameter logic [SLOT_WIDTH-1:0] SLOT_ID = 4'h1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Command
  input wire logic cmd_valid,
  input wire etc_op_type cmd_op,
  input wire logic [SLOT_WIDTH-1:0] cmd_slot,
  input wire logic [N-1:0] cmd_chans,
  input wire logic cmd_falling_edge_select,
  input wire logic cmd_ready,
  input wire logic [N-1:0] scan_list,
  // Response and status
  input wire logic resp_valid,
  input wire etc_resp_type resp_kind,
  input wire logic [7:0] resp_char,
  input wire logic [LOCAL_WIDTH-1:0] resp_local,
  input wire logic resp_last,
  input wire logic [N-1:0] falling_edge_select,
  input wire logic [N-1:0] read_and_clear_mode,
  input wire logic [N-1:0] count_enabled
);
  logic take;
  logic [N-1:0] eff;
  assign take = clk_en && cmd_valid && cmd_ready
    && ((cmd_slot == SLOT_ID) || (cmd_op inside {OP_FACTORY_RESET, OP_PRESET, OP_CARD_RESET}));
  assign eff = (cmd_chans != '0) ? cmd_chans : scan_list;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_start;
    take && cmd_op == OP_START |-> ##2 (count_enabled & $past(eff, 2)) == $past(eff, 2);
  endproperty
  a_start: assert property (p_start) else $error("start missed a channel");
  property p_stop;
    take && cmd_op == OP_STOP |-> ##2 (count_enabled & $past(eff, 2)) == '0;
  endproperty
  a_stop: assert property (p_stop) else $error("stop missed a channel");
  property p_slope;
    take && cmd_op == OP_SET_SLOPE |-> ##2
      (falling_edge_select & $past(eff, 2)) == ($past(eff, 2) & {N{$past(cmd_falling_edge_select, 2)}});
  endproperty
  a_slope: assert property (p_slope) else $error("edge select not applied");
  property p_config;
    take && cmd_op == OP_CONFIGURE |-> ##2 (falling_edge_select & $past(eff, 2)) == '0;
  endproperty
  a_config: assert property (p_config) else $error("configure left falling edge");
  property p_factory;
    take && cmd_op == OP_FACTORY_RESET |-> ##2 falling_edge_select == '0 && read_and_clear_mode == '0;
  endproperty
  a_factory: assert property (p_factory) else $error("factory reset left settings");
  property p_preset;
    take && cmd_op inside {OP_PRESET, OP_CARD_RESET} |-> ##2 falling_edge_select == $past(falling_edge_select, 2);
  endproperty
  a_preset: assert property (p_preset) else $error("preset changed edge select");
  property p_query;
    take && cmd_op inside {OP_QUERY_SLOPE, OP_QUERY_START_DEFAULT, OP_READ} && eff != '0
      |-> ##2 !cmd_ready ##[0:40] resp_valid && resp_last;
  endproperty
  a_query: assert property (p_query) else $error("query response incomplete");
  property p_local;
    resp_valid && resp_kind == RESP_COUNT |-> resp_local inside {[5:8]};
  endproperty
  a_local: assert property (p_local) else $error("channel number out of range");
  property p_char;
    resp_valid && resp_kind == RESP_TEXT |-> resp_char inside {8'h4E, 8'h45, 8'h47, 8'h50, 8'h4F, 8'h53,
      8'h31, 8'h30, 8'h2C};
  endproperty
  a_char: assert property (p_char) else $error("bad response character");
endmodule
bind etc_totalizer etc_totalizer_chk #(.N(N), .SLOT_ID(SLOT_ID)) u_chk (.core_clk, .rst, .clk_en, .cmd_valid,
  .cmd_op, .cmd_slot, .cmd_chans, .cmd_falling_edge_select, .cmd_ready, .scan_list, .resp_valid, .resp_kind,
  .resp_char, .resp_local, .resp_last, .falling_edge_select, .read_and_clear_mode, .count_enabled);

// file: tb/etc_totalizer_tb_top.sv
// Self-checking bench for the edge totalizer control
`timescale 1ns/100ps
module etc_totalizer_tb_top;
  import etc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  etc_op_type cmd_op = OP_NONE;
  logic [3:0] cmd_slot = 4'h1;
  logic [3:0] cmd_chans = 4'h0;
  logic cmd_arg = 1'b0;
  logic [3:0] scan_list = 4'h4;
  logic cmd_ready, resp_valid;
  etc_resp_type resp_kind;
  logic [7:0] resp_char;
  logic [31:0] resp_count;
  logic [3:0] pulse_in, fall_sel, rc_mode, cnt_en;
  logic [3:0] pon_flag, rsp_slot;
  logic clk_en = 1'b1;
  logic [7:0] txt[$];
  logic [31:0] cnt[$];
  int n_errors = 0;
  int n_compared = 0;

  always #10 core_clk = ~core_clk;

  etc_pulse_src src (.core_clk(core_clk), .pulse_in(pulse_in));
  etc_totalizer dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .pulse_in(pulse_in), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_slot(cmd_slot), .cmd_chans(cmd_chans), .cmd_falling_edge_select(cmd_arg),
    .cmd_read_and_clear_mode(cmd_arg), .cmd_ready(cmd_ready), .scan_list(scan_list), .pon_start_stored(4'h5),
    .resp_valid(resp_valid), .resp_kind(resp_kind), .resp_char(resp_char), .resp_count(resp_count),
    .resp_slot(rsp_slot), .resp_local(), .resp_last(), .falling_edge_select(fall_sel), .read_and_clear_mode(rc_mode),
    .count_enabled(cnt_en), .pon_start_flag(pon_flag));

  always @(negedge core_clk) begin
    if (resp_valid === 1'b1 && resp_kind === RESP_TEXT) txt.push_back(resp_char);
    if (resp_valid === 1'b1 && resp_kind === RESP_COUNT) cnt.push_back(resp_count);
  end

  task automatic stop_test;
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Held until taken, then one more cycle so status outputs have landed
  task automatic send(input etc_op_type op, input logic [3:0] ch, input logic a);
    int k;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_chans = ch;
    cmd_arg = a;
    for (k = 0; k < 50 && cmd_ready !== 1'b1; k++) @(negedge core_clk);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic query(input etc_op_type op, input logic [3:0] ch, input string exp);
    int k;
    txt.delete();
    cnt.delete();
    send(op, ch, 1'b0);
    for (k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(negedge core_clk);
    if (op != OP_READ) chk(txt.size(), exp.len());
    foreach (txt[i]) chk(txt[i], exp[i]);
  endtask

  task automatic rd4(input logic [127:0] e);
    query(OP_READ, 4'hF, "");
    chk(cnt.size(), 4);
    foreach (cnt[i]) chk(cnt[i], e[i*32+:32]);
  endtask

  initial begin
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(cnt_en, 4'h5);
    query(OP_QUERY_START_DEFAULT, 4'hF, "1,0,1,0");
    chk(rsp_slot, 4'h1);
    send(OP_START_DEFAULT, 4'h2, 1'b0);
    chk(pon_flag, 4'h7);
    query(OP_QUERY_START_DEFAULT, 4'h3, "1,1");
    send(OP_STOP, 4'h0, 1'b0);
    chk(cnt_en, 4'h1);
    send(OP_SET_SLOPE, 4'h5, 1'b1);
    chk(fall_sel, 4'h5);
    query(OP_QUERY_SLOPE, 4'h3, "NEG,POS");
    send(OP_CLEAR, 4'hF, 1'b0);
    send(OP_START, 4'hF, 1'b0);
    chk(cnt_en, 4'hF);
    // Frozen clock enable must ignore a full pulse
    clk_en = 1'b0;
    src.burst(2);
    clk_en = 1'b1;
    src.burst(5);
    repeat (3) @(negedge core_clk);
    send(OP_STOP, 4'hF, 1'b0);
    rd4({32'h3, 32'h2, 32'h3, 32'h2});
    src.burst(3);
    rd4({32'h3, 32'h2, 32'h3, 32'h2});
    cmd_slot = 4'h2;
    send(OP_START, 4'hF, 1'b0);
    chk(cnt_en, 4'h0);
    cmd_slot = 4'h1;
    send(OP_SET_MODE, 4'h1, 1'b1);
    chk(rc_mode, 4'h1);
    rd4({32'h3, 32'h2, 32'h3, 32'h2});
    rd4({32'h3, 32'h2, 32'h3, 32'h0});
    send(OP_CONFIGURE, 4'h1, 1'b0);
    chk({fall_sel, rc_mode}, 8'h40);
    send(OP_PRESET, 4'h0, 1'b0);
    send(OP_CARD_RESET, 4'h0, 1'b0);
    chk(fall_sel, 4'h4);
    rd4({32'h3, 32'h2, 32'h3, 32'h0});
    send(OP_FACTORY_RESET, 4'h0, 1'b0);
    chk(fall_sel, 4'h0);
    rd4(128'h0);
    stop_test;
  end

  initial begin
    #100us;
    n_errors++;
    stop_test;
  end
endmodule
